// *** src/modulus_defines.svh ***
// Constants for the programmable modulus and source priority block.
// Assumes inclusion by bare name from the design and verification files.
// Contract
// - Ramp generator doubles as auxiliary accumulator
// - Output frequency equals clock times (word+A/B)/2^32
// - Auxiliary accumulator adds A, wraps at B
// - Each wrap adds one LSB to phase
// - Modulus mode owns frequency exclusively
// - Modulus mode stops ramp sweeping phase, amplitude
// - Modulus mode phase comes from selected profile
// - Profile amplitude needs output keying enable bit
// - Ramp second; other parameters from profiles
// - Profiles third, drive all three parameters
// - Parallel port lowest, only when unclaimed
// - Profile beats parallel port on tuning word
// - Ramp uses 32, 16, 12 upper bits
// - Output keying overrides every other amplitude source
// - Profile pins applied at next data clock
`ifndef MODULUS_DEFINES_SVH
`define MODULUS_DEFINES_SVH

`define ADDR_CTRL_ONE 8'h00
`define ADDR_CFR2 8'h01
`define ADDR_TUNING 8'h04
`define ADDR_DEN 8'h05
`define ADDR_NUM 8'h06
`define ADDR_STATUS 8'h0A
`define ADDR_PROF_BASE 8'h0B
`define ADDR_PROF_END 8'h1B

`define KEYING_EN_BIT 8
`define KEYING_AUTO_BIT 9
`define CFR2_PROF_EN 23
`define CFR2_PAR_EN 22
`define CFR2_RAMP_DEST_MSB 21
`define CFR2_RAMP_DEST_LSB 20
`define CFR2_RAMP_EN 19
`define CFR2_MOD_EN 18
`define CFR2_PAR_DEST_MSB 17
`define CFR2_PAR_DEST_LSB 16

`define PROF_PH_MSB 15
`define PROF_PH_LSB 0
`define PROF_AMP_MSB 27
`define PROF_AMP_LSB 16
`define WORD_PH_LSB 16
`define WORD_AMP_LSB 20

`define RST_WORD 32'h0000_0000
`define RST_PHASE 16'h0000
`define AMP_FULL 12'hFFF
`define STATUS_PAD 28'h000_0000
`define DATA_DIV_LAST 5'h17

`endif

// *** src/modulus_pkg.sv ***
// Types shared by the modulus and source priority design.
// Assumes the constants header is included by each design file.
package modulus_pkg;

   typedef struct packed {
      logic [31:0] freq;
      logic [15:0] phase;
      logic [11:0] amp;
   } dds_param_t;

   typedef enum logic [1:0] {
      DEST_FREQ = 2'h0,
      DEST_PHASE = 2'h1,
      DEST_AMP = 2'h3
   } dest_t;

   typedef struct packed {
      logic io_update;
      logic [2:0] profile;
      logic [31:0] data;
   } pin_bus_t;

endpackage

// *** src/pin_capture.sv ***
// Pin synchronisers and the divide-by-24 data clock enable.
// Assumes pins are asynchronous to sys_clk.
`timescale 1ns/100ps
`include "modulus_defines.svh"

module pin_capture (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Raw pins
   input wire modulus_pkg::pin_bus_t pins_raw,
   // Synchronised pins and data clock enable
   output modulus_pkg::pin_bus_t pins_sync,
   output logic data_clk_en
);
   modulus_pkg::pin_bus_t meta_ff;
   modulus_pkg::pin_bus_t sync_ff;
   logic [4:0] div_ff;
   logic tick_ff;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= pins_raw;
         sync_ff <= meta_ff;
      end
   end

   // Data clock runs at one twenty-fourth of sys_clk
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_ff <= 5'h0;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= (div_ff == `DATA_DIV_LAST);
         if (div_ff == `DATA_DIV_LAST) begin
            div_ff <= 5'h0;
         end else begin
            div_ff <= div_ff + 5'h1;
         end
      end
   end

   assign pins_sync = sync_ff;
   assign data_clk_en = tick_ff;
endmodule

// *** src/aux_accum.sv ***
// Auxiliary accumulator of the programmable modulus.
// Assumes the host keeps numerator below denominator.
`timescale 1ns/100ps
`include "modulus_defines.svh"

module aux_accum (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Control
   input wire logic enable,
   input wire logic [31:0] numerator,
   input wire logic [31:0] denominator,
   // Result
   output logic wrap,
   output logic [31:0] accum
);
   logic [31:0] acc_ff;
   logic [32:0] sum;
   logic [32:0] nxt_acc;

   always_comb begin
      sum = {1'b0, acc_ff} + {1'b0, numerator};
      wrap = enable && (sum >= {1'b0, denominator});
      nxt_acc = wrap ? sum - {1'b0, denominator} : sum;
   end

   // Cleared while idle so a new modulus starts from a known phase
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_ff <= `RST_WORD;
      end else if (!enable) begin
         acc_ff <= `RST_WORD;
      end else begin
         acc_ff <= nxt_acc[31:0];
      end
   end

   assign accum = acc_ff;

   chk_aux_below_den: assert property (@(posedge sys_clk) disable iff (!rst_b)
      enable && numerator < denominator && acc_ff < denominator
      |=> acc_ff < $past(denominator))
      else $error("auxiliary accumulator passed denominator");

   chk_aux_wrap_sub: assert property (@(posedge sys_clk) disable iff (!rst_b)
      wrap |=> acc_ff == $past(acc_ff) + $past(numerator) - $past(denominator))
      else $error("auxiliary accumulator wrap value wrong");
endmodule

// *** src/modulus_priority.sv ***
// Programmable modulus phase accumulator and parameter source mux.
// Assumes ramp and keying sources are on sys_clk; pins are not.
`timescale 1ns/100ps
`include "modulus_defines.svh"

module modulus_priority (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Register port
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // Pins
   input wire logic io_update,
   input wire logic [2:0] profile_select_pins,
   input wire logic [31:0] par_data,
   // Internal modulation sources
   input wire logic [31:0] ramp_value,
   input wire logic [11:0] output_keying_amp,
   // Results
   output modulus_pkg::dds_param_t dds_param,
   output logic [31:0] phase_accum,
   output logic ramp_claimed
);
   // Buffered and active registers
   logic [31:0] ctrl1_buf_ff;
   logic [31:0] cfr2_buf_ff;
   logic [31:0] tune_buf_ff;
   logic [31:0] den_buf_ff;
   logic [31:0] num_buf_ff;
   logic [31:0] ctrl1_ff;
   logic [31:0] cfr2_ff;
   logic [31:0] tune_ff;
   logic [31:0] den_ff;
   logic [31:0] num_ff;
   logic [31:0] prof_mem [0:15];
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic upd_q_ff;
   logic upd_pulse;
   logic prof_hit;
   logic [3:0] prof_idx;

   // Pin capture
   modulus_pkg::pin_bus_t pins_raw;
   modulus_pkg::pin_bus_t pins_sync;
   logic data_clk_en;
   logic [2:0] prof_sel_ff;
   logic [31:0] par_ff;

   // Source selection
   logic mod_on;
   logic ramp_sweep;
   logic prof_en;
   logic par_en;
   logic keying_en;
   logic keying_auto;
   modulus_pkg::dest_t ramp_dest;
   modulus_pkg::dest_t par_dest;
   logic [31:0] prof_freq;
   logic [15:0] prof_phase;
   logic [11:0] prof_amp;
   modulus_pkg::dds_param_t nxt_param;
   modulus_pkg::dds_param_t param_ff;

   // Phase accumulation
   logic aux_wrap;
   logic [31:0] phase_ff;
   logic [31:0] nxt_phase;
   logic claim_ff;

   assign pins_raw = '{io_update: io_update, profile: profile_select_pins, data: par_data};

   pin_capture u_pins (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pins_raw(pins_raw),
      .pins_sync(pins_sync),
      .data_clk_en(data_clk_en)
   );

   assign upd_pulse = pins_sync.io_update && !upd_q_ff;
   assign prof_hit = (reg_addr >= `ADDR_PROF_BASE) && (reg_addr < `ADDR_PROF_END);
   assign prof_idx = 4'(reg_addr - `ADDR_PROF_BASE);

   // Host writes land in buffers; io_update moves them to active
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl1_buf_ff <= `RST_WORD;
         cfr2_buf_ff <= `RST_WORD;
         tune_buf_ff <= `RST_WORD;
         den_buf_ff <= `RST_WORD;
         num_buf_ff <= `RST_WORD;
      end else if (reg_wr_en) begin
         if (reg_addr == `ADDR_CTRL_ONE) begin
            ctrl1_buf_ff <= reg_wdata;
         end else if (reg_addr == `ADDR_CFR2) begin
            cfr2_buf_ff <= reg_wdata;
         end else if (reg_addr == `ADDR_TUNING) begin
            tune_buf_ff <= reg_wdata;
         end else if (reg_addr == `ADDR_DEN) begin
            den_buf_ff <= reg_wdata;
         end else if (reg_addr == `ADDR_NUM) begin
            num_buf_ff <= reg_wdata;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         upd_q_ff <= 1'b0;
         ctrl1_ff <= `RST_WORD;
         cfr2_ff <= `RST_WORD;
         tune_ff <= `RST_WORD;
         den_ff <= `RST_WORD;
         num_ff <= `RST_WORD;
      end else begin
         upd_q_ff <= pins_sync.io_update;
         if (upd_pulse) begin
            ctrl1_ff <= ctrl1_buf_ff;
            cfr2_ff <= cfr2_buf_ff;
            tune_ff <= tune_buf_ff;
            den_ff <= den_buf_ff;
            num_ff <= num_buf_ff;
         end
      end
   end

   // Profiles are written straight through, with no buffering
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 16; i++) begin
            prof_mem[i] <= `RST_WORD;
         end
      end else if (reg_wr_en && prof_hit) begin
         prof_mem[prof_idx] <= reg_wdata;
      end
   end

   // Profile pins and port data change only on the data clock
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prof_sel_ff <= 3'h0;
         par_ff <= `RST_WORD;
      end else if (data_clk_en) begin
         prof_sel_ff <= pins_sync.profile;
         par_ff <= pins_sync.data;
      end
   end

   always_comb begin
      nxt_rdata = `RST_WORD;
      if (reg_addr == `ADDR_CTRL_ONE) begin
         nxt_rdata = ctrl1_ff;
      end else if (reg_addr == `ADDR_CFR2) begin
         nxt_rdata = cfr2_ff;
      end else if (reg_addr == `ADDR_TUNING) begin
         nxt_rdata = tune_ff;
      end else if (reg_addr == `ADDR_DEN) begin
         nxt_rdata = den_ff;
      end else if (reg_addr == `ADDR_NUM) begin
         nxt_rdata = num_ff;
      end else if (reg_addr == `ADDR_STATUS) begin
         nxt_rdata = {`STATUS_PAD, mod_on, prof_sel_ff};
      end else if (prof_hit) begin
         nxt_rdata = prof_mem[prof_idx];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= `RST_WORD;
      end else if (reg_rd_en) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign mod_on = cfr2_ff[`CFR2_MOD_EN];
   assign ramp_sweep = cfr2_ff[`CFR2_RAMP_EN] && !mod_on;
   assign prof_en = cfr2_ff[`CFR2_PROF_EN];
   assign par_en = cfr2_ff[`CFR2_PAR_EN];
   assign keying_en = ctrl1_ff[`KEYING_EN_BIT];
   assign keying_auto = ctrl1_ff[`KEYING_AUTO_BIT];
   assign ramp_dest = modulus_pkg::dest_t'(cfr2_ff[`CFR2_RAMP_DEST_MSB:`CFR2_RAMP_DEST_LSB]);
   assign par_dest = modulus_pkg::dest_t'(cfr2_ff[`CFR2_PAR_DEST_MSB:`CFR2_PAR_DEST_LSB]);
   assign prof_freq = prof_mem[{prof_sel_ff, 1'b0}];
   assign prof_phase = prof_mem[{prof_sel_ff, 1'b1}][`PROF_PH_MSB:`PROF_PH_LSB];
   assign prof_amp = prof_mem[{prof_sel_ff, 1'b1}][`PROF_AMP_MSB:`PROF_AMP_LSB];

   // Fixed priority: modulus, ramp, profiles, parallel port; on amplitude, output keying comes before ramp
   always_comb begin
      nxt_param.freq = tune_ff;
      if (mod_on) begin
         nxt_param.freq = tune_ff;
      end else if (ramp_sweep && ramp_dest == modulus_pkg::DEST_FREQ) begin
         nxt_param.freq = ramp_value;
      end else if (prof_en) begin
         nxt_param.freq = prof_freq;
      end else if (par_en && par_dest == modulus_pkg::DEST_FREQ) begin
         nxt_param.freq = par_ff;
      end

      nxt_param.phase = `RST_PHASE;
      if (ramp_sweep && ramp_dest == modulus_pkg::DEST_PHASE) begin
         nxt_param.phase = ramp_value[31:`WORD_PH_LSB];
      end else if (prof_en) begin
         nxt_param.phase = prof_phase;
      end else if (par_en && par_dest == modulus_pkg::DEST_PHASE) begin
         nxt_param.phase = par_ff[31:`WORD_PH_LSB];
      end

      // Without the keying enable the scaler stays at full scale
      nxt_param.amp = `AMP_FULL;
      if (!keying_en) begin
         nxt_param.amp = `AMP_FULL;
      end else if (keying_auto) begin
         nxt_param.amp = output_keying_amp;
      end else if (ramp_sweep && ramp_dest == modulus_pkg::DEST_AMP) begin
         nxt_param.amp = ramp_value[31:`WORD_AMP_LSB];
      end else if (prof_en) begin
         nxt_param.amp = prof_amp;
      end else if (par_en && par_dest == modulus_pkg::DEST_AMP) begin
         nxt_param.amp = par_ff[31:`WORD_AMP_LSB];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         param_ff <= '{freq: `RST_WORD, phase: `RST_PHASE, amp: `AMP_FULL};
      end else begin
         param_ff <= nxt_param;
      end
   end

   // The ramp generator is lent out as the auxiliary accumulator
   aux_accum u_aux (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .enable(mod_on),
      .numerator(num_ff),
      .denominator(den_ff),
      .wrap(aux_wrap),
      .accum()
   );

   // Carry adds one LSB, stretching the modulus to B times 2^32
   assign nxt_phase = phase_ff + param_ff.freq + {31'h0, aux_wrap};

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_ff <= `RST_WORD;
         claim_ff <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
         claim_ff <= mod_on;
      end
   end

   assign reg_rdata = rdata_ff;
   assign dds_param = param_ff;
   assign phase_accum = phase_ff;
   assign ramp_claimed = claim_ff;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   chk_mod_owns_freq: assert property (
      mod_on |=> dds_param.freq == $past(tune_ff))
      else $error("modulus mode lost the frequency");

   chk_ramp_no_phase: assert property (
      mod_on && !prof_en && !par_en |=> dds_param.phase == `RST_PHASE)
      else $error("ramp reached phase in modulus mode");

   chk_prof_phase: assert property (
      mod_on && prof_en |=> dds_param.phase == $past(prof_phase))
      else $error("profile phase not used in modulus mode");

   chk_keying_gate: assert property (
      !keying_en |=> dds_param.amp == `AMP_FULL)
      else $error("amplitude driven without keying enable");

   chk_keying_wins: assert property (
      keying_en && keying_auto |=> dds_param.amp == $past(output_keying_amp))
      else $error("keying amplitude overridden");

   chk_ramp_freq: assert property (
      !mod_on && cfr2_ff[`CFR2_RAMP_EN] && ramp_dest == modulus_pkg::DEST_FREQ && prof_en
      |=> dds_param.freq == $past(ramp_value) && dds_param.phase == $past(prof_phase))
      else $error("ramp frequency or profile phase wrong");

   chk_prof_over_par: assert property (
      !mod_on && !cfr2_ff[`CFR2_RAMP_EN] && prof_en && par_en
      && par_dest == modulus_pkg::DEST_FREQ |=> dds_param.freq == $past(prof_freq))
      else $error("parallel port beat profile on frequency");

   chk_par_last: assert property (
      !mod_on && !cfr2_ff[`CFR2_RAMP_EN] && !prof_en && par_en
      && par_dest == modulus_pkg::DEST_FREQ |=> dds_param.freq == $past(par_ff))
      else $error("parallel port frequency not applied");

   chk_phase_plain: assert property (
      !mod_on |=> phase_accum == $past(phase_accum) + $past(dds_param.freq))
      else $error("phase step wrong without modulus");

   chk_phase_carry: assert property (
      aux_wrap |=> phase_accum == $past(phase_accum) + $past(dds_param.freq) + 32'h1)
      else $error("wrap carry not added to phase");

   chk_prof_hold: assert property (
      !data_clk_en |=> $stable(prof_sel_ff))
      else $error("profile changed off the data clock");

   cov_mod_wrap: cover property (mod_on ##1 aux_wrap);
   cov_prof_switch: cover property (data_clk_en ##1 $changed(prof_sel_ff));
   cov_keying_auto: cover property (keying_en && keying_auto && prof_en);
endmodule

// *** verif/host_model.sv ***
// Host controller model: register writes and reads, update pin, profile and port pins.
// Assumes one sys_clk; every request changes just after a rising edge.
`timescale 1ns/100ps
`include "modulus_defines.svh"

module host_model (
   // Clock
   input wire logic sys_clk,
   // Register port
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [7:0] reg_addr,
   output logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   // Pins
   output logic io_update,
   output logic [2:0] profile_select_pins,
   output logic [31:0] par_data
);
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      io_update = 1'b0;
      profile_select_pins = 3'h0;
      par_data = 32'h0000_0000;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd_en <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // Held high two cycles so the synchroniser cannot miss it
   task automatic update();
      @(posedge sys_clk);
      io_update <= 1'b1;
      repeat (2) @(posedge sys_clk);
      io_update <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask

   // Held well past one data clock period so a capture is certain
   task automatic pins(input logic [2:0] p, input logic [31:0] d);
      @(posedge sys_clk);
      profile_select_pins <= p;
      par_data <= d;
      repeat (60) @(posedge sys_clk);
   endtask

   // Ratio m/n scaled by 2^32, split into integer word and reduced remainder fraction
   task automatic program_modulus(input logic [31:0] m, input logic [31:0] n);
      logic [63:0] w;
      logic [63:0] y;
      logic [63:0] g;
      logic [63:0] b;
      logic [63:0] t;
      w = ({m, 32'h0000_0000}) / n;
      y = ({m, 32'h0000_0000}) - w * n;
      g = n;
      b = y;
      while (b != 64'h0) begin
         t = g % b;
         g = b;
         b = t;
      end
      wr(`ADDR_TUNING, w[31:0]);
      wr(`ADDR_DEN, 32'(n / g));
      wr(`ADDR_NUM, 32'(y / g));
   endtask
endmodule

// *** verif/modulus_priority_tb.sv ***
// Self-checking bench for the modulus phase accumulator and source priority mux.
// Assumes host_model drives the register port and pins of the block.
`timescale 1ns/100ps
`include "modulus_defines.svh"

module modulus_priority_tb;
   localparam logic [31:0] W = 32'h4CCC_CCCC;
   localparam logic [31:0] RAMP = 32'h9876_5432;
   logic sys_clk;
   logic rst_b;
   logic reg_wr_en;
   logic reg_rd_en;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic io_update;
   logic [2:0] profile_select_pins;
   logic [31:0] par_data;
   logic [31:0] ramp_value;
   logic [11:0] output_keying_amp;
   modulus_pkg::dds_param_t dds_param;
   logic [31:0] phase_accum;
   logic ramp_claimed;
   int mismatches;
   int checks_done;

   host_model host (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .io_update(io_update), .profile_select_pins(profile_select_pins), .par_data(par_data));

   modulus_priority dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .io_update(io_update),
      .profile_select_pins(profile_select_pins), .par_data(par_data),
      .ramp_value(ramp_value), .output_keying_amp(output_keying_amp),
      .dds_param(dds_param), .phase_accum(phase_accum), .ramp_claimed(ramp_claimed));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic apply_cfg(input logic [31:0] ctrl1, input logic [31:0] ctrl2);
      host.wr(`ADDR_CTRL_ONE, ctrl1);
      host.wr(`ADDR_CFR2, ctrl2);
      host.update();
   endtask

   // Accumulator advance over n cycles
   task automatic step(input int n, output logic [31:0] d);
      logic [31:0] p0;
      @(posedge sys_clk);
      #1;
      p0 = phase_accum;
      repeat (n) @(posedge sys_clk);
      #1;
      d = phase_accum - p0;
   endtask

   task automatic t_reset();
      cmp("reset freq", 32'h0, dds_param.freq);
      cmp("reset phase", 32'h0, {16'h0, dds_param.phase});
      cmp("reset amp", 32'h0FFF, {20'h0, dds_param.amp});
      cmp("reset accum", 32'h0, phase_accum);
      cmp("reset claimed", 32'h0, {31'h0, ramp_claimed});
   endtask

   task automatic t_modulus();
      logic [31:0] d;
      host.program_modulus(32'h3, 32'hA);
      // Ramp also asks for frequency, modulus must still win
      apply_cfg(32'h0, 32'h000C_0000);
      cmp("mod freq", W, dds_param.freq);
      cmp("mod claimed", 32'h1, {31'h0, ramp_claimed});
      step(5, d);
      cmp("mod advance", 32'h8000_0000, d);
      step(10, d);
      cmp("mod advance 10", 32'h0000_0000, d);
      host.rd(`ADDR_TUNING, d);
      cmp("rd word", W, d);
      host.rd(`ADDR_DEN, d);
      cmp("rd den", 32'h5, d);
      host.rd(`ADDR_NUM, d);
      cmp("rd num", 32'h4, d);
      host.rd(`ADDR_STATUS, d);
      cmp("rd status", 32'h8, d);
      host.rd(8'h30, d);
      cmp("rd unmapped", 32'h0, d);
   endtask

   task automatic t_mod_phase();
      host.wr(8'h0C, 32'h0123_4567);
      // Ramp aimed at phase, profile mode on
      apply_cfg(32'h0, 32'h009D_0000);
      host.pins(3'h0, 32'h0);
      cmp("mod phase", 32'h4567, {16'h0, dds_param.phase});
      cmp("mod amp off", 32'h0FFF, {20'h0, dds_param.amp});
      apply_cfg(32'h0000_0100, 32'h009D_0000);
      cmp("mod amp", 32'h0123, {20'h0, dds_param.amp});
   endtask

   task automatic t_plain();
      logic [31:0] d;
      apply_cfg(32'h0, 32'h0);
      cmp("plain claimed", 32'h0, {31'h0, ramp_claimed});
      step(1, d);
      cmp("plain step", W, d);
      step(5, d);
      cmp("plain advance", 32'h7FFF_FFFC, d);
   endtask

   task automatic t_ramp();
      // Profile 0 frequency, used once the ramp moves to phase
      host.wr(8'h0B, 32'h1357_9BDF);
      apply_cfg(32'h0000_0100, 32'h0088_0000);
      cmp("ramp freq", RAMP, dds_param.freq);
      cmp("ramp keeps phase", 32'h4567, {16'h0, dds_param.phase});
      apply_cfg(32'h0000_0100, 32'h0098_0000);
      cmp("ramp phase", 32'h9876, {16'h0, dds_param.phase});
      cmp("ramp keeps freq", 32'h1357_9BDF, dds_param.freq);
      apply_cfg(32'h0000_0100, 32'h00B8_0000);
      cmp("ramp amp", 32'h0987, {20'h0, dds_param.amp});
      apply_cfg(32'h0000_0300, 32'h00B8_0000);
      cmp("keying amp", 32'h0A5C, {20'h0, dds_param.amp});
   endtask

   task automatic t_prof_par();
      logic [31:0] d;
      host.wr(8'h0F, 32'h0ABC_0000);
      apply_cfg(32'h0, 32'h00C0_0000);
      host.pins(3'h2, 32'h5555_AAAA);
      cmp("profile over port", 32'h0ABC_0000, dds_param.freq);
      host.rd(`ADDR_STATUS, d);
      cmp("status profile", 32'h2, d);
      apply_cfg(32'h0, 32'h0040_0000);
      cmp("port freq", 32'h5555_AAAA, dds_param.freq);
      apply_cfg(32'h0, 32'h0041_0000);
      cmp("port phase", 32'h5555, {16'h0, dds_param.phase});
      apply_cfg(32'h0000_0100, 32'h0043_0000);
      cmp("port amp", 32'h0555, {20'h0, dds_param.amp});
   endtask

   initial begin
      mismatches = 0;
      checks_done = 0;
      rst_b <= 1'b0;
      ramp_value <= RAMP;
      output_keying_amp <= 12'hA5C;
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      #1;
      t_reset();
      t_modulus();
      t_mod_phase();
      t_plain();
      t_ramp();
      t_prof_par();
      summarize();
   end

   initial begin
      #200000;
      mismatches++;
      summarize();
   end
endmodule
